// [logic/seq_limit_regs.sv]
// Purpose : Limit and hold registers of the trigger step sequencer, APB slave
// Assumes : Step engine on pclk drives the command pulses and copy requests
// Notes   : One wait state on every APB access
//
// Function
// - A 16-bit timer-0 limit is held and applied as terminal count only on the timer-0 step command.
// - A separate 16-bit timer-1 limit is held and applied only on the timer-1 step command.
// - While enable and start are both set, software writes to the limits and the hold word are ignored.
// - The counter-1 limit serves as loop count of the counter-1 conditional jump step.
// - The counter-1 limit may instead serve as terminal limit of general-purpose counter 1.
// - A copy command moves the hold word into a timer limit, counter limit, step delay or literal-0.
// - The timer-0 limit is fully readable and writable and resets to zero.
//
// Chosen here: the placing of the registers and the APB register port.
`timescale 1ns/10ps
`include "seq_limit_cfg.svh"
module seq_limit_regs #(
    parameter int LIMIT_W = 16
) (
    // Clock, reset, enable
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    input  wire logic                       ce,
    // APB slave
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [7:0]                 paddr,
    input  wire logic [31:0]                pwdata,
    output logic      [31:0]                prdata,
    output logic                            pready,
    output logic                            pslverr,
    // Step engine commands
    input  wire logic                       timer0_step_cmd,
    input  wire logic                       timer1_step_cmd,
    input  wire logic                       counter1_jump_command,
    input  wire logic                       counter1_gp_load,
    input  wire seq_limit_pkg::copy_req_t   copy_hold_command,
    // Values handed to the engine
    output logic      [LIMIT_W-1:0]         timer0_terminal,
    output logic      [LIMIT_W-1:0]         timer1_terminal,
    output logic      [LIMIT_W-1:0]         counter1_loop_count,
    output logic      [LIMIT_W-1:0]         counter1_gp_limit,
    output seq_limit_pkg::ext_load_t        copy_load,
    output logic                            sequencer_locked
);

    // ---------------------------------------------------------------
    // Elaboration check
    // ---------------------------------------------------------------
    if (LIMIT_W != 16) begin : g_bad
        $error("seq_limit_regs: LIMIT_W must be 16");
    end

    // ---------------------------------------------------------------
    // Declarations
    // ---------------------------------------------------------------
    seq_limit_pkg::bus_state_t  state;
    seq_limit_pkg::bus_state_t  next_state;
    logic [4*LIMIT_W-1:0]       words;
    logic [4*LIMIT_W-1:0]       wr_data;
    logic [3:0]                 wr_en;
    logic [1:0]                 control;
    logic [1:0]                 next_control;
    logic [31:0]                next_prdata;
    logic                       next_pready;
    logic                       next_pslverr;
    logic                       next_locked;
    logic                       done;
    logic                       sw_write;
    logic                       mapped;
    logic                       locked;
    logic [LIMIT_W-1:0]         timer0_limit;
    logic [LIMIT_W-1:0]         timer1_limit;
    logic [LIMIT_W-1:0]         counter1_limit;
    logic [LIMIT_W-1:0]         general_hold;
    seq_limit_pkg::ext_load_t   next_copy_load;
    logic [LIMIT_W-1:0]         next_t0;
    logic [LIMIT_W-1:0]         next_t1;
    logic [LIMIT_W-1:0]         next_loop;
    logic [LIMIT_W-1:0]         next_gp;

    assign timer0_limit   = words[0*LIMIT_W +: LIMIT_W];
    assign timer1_limit   = words[1*LIMIT_W +: LIMIT_W];
    assign counter1_limit = words[2*LIMIT_W +: LIMIT_W];
    assign general_hold   = words[3*LIMIT_W +: LIMIT_W];
    assign locked         = control[`BIT_SEQ_ENABLE] & control[`BIT_SEQ_START];
    assign done           = psel & penable & pready;
    assign sw_write       = done & pwrite;

    // ---------------------------------------------------------------
    // Bus handshake: setup, one wait, ready
    // ---------------------------------------------------------------
    always_comb begin
        next_state = state;
        case (state)
            seq_limit_pkg::BUS_IDLE: if (psel && !penable) next_state = seq_limit_pkg::BUS_WAIT;
            seq_limit_pkg::BUS_WAIT: if (psel && penable) next_state = seq_limit_pkg::BUS_DONE;
            seq_limit_pkg::BUS_DONE: next_state = seq_limit_pkg::BUS_IDLE;
            default:                 next_state = seq_limit_pkg::BUS_IDLE;
        endcase
        next_pready = (next_state == seq_limit_pkg::BUS_DONE);
    end

    // Address decode and read data
    always_comb begin
        mapped      = 1'b1;
        next_prdata = 32'h0000_0000;
        case (paddr)
            `OFS_TIMER0_LIMIT:   next_prdata = {16'h0000, timer0_limit};
            `OFS_TIMER1_LIMIT:   next_prdata = {16'h0000, timer1_limit};
            `OFS_COUNTER1_LIMIT: next_prdata = {16'h0000, counter1_limit};
            `OFS_GENERAL_HOLD:   next_prdata = {16'h0000, general_hold};
            `OFS_SEQ_CONTROL:    next_prdata = {30'h0000_0000, control};
            `OFS_SEQ_STATUS:     next_prdata = {31'h0000_0000, locked};
            default:             mapped = 1'b0;
        endcase
        next_pslverr = next_pready & ~mapped;
        if (!next_pready || pwrite || !mapped) begin
            next_prdata = 32'h0000_0000;
        end
    end

    // Register bus outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state   <= seq_limit_pkg::BUS_IDLE;
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else if (ce) begin
            state   <= next_state;
            pready  <= next_pready;
            pslverr <= next_pslverr;
            prdata  <= next_prdata;
        end
    end

    // ---------------------------------------------------------------
    // Word writes: copy from the engine wins over software
    // ---------------------------------------------------------------
    always_comb begin
        wr_en   = 4'h0;
        wr_data = '0;
        for (int i = 0; i < 4; i++) begin
            if (copy_hold_command.valid && i < 3 && copy_hold_command.target == 3'(i)) begin
                wr_en[i]                     = 1'b1;
                wr_data[i*LIMIT_W +: LIMIT_W] = general_hold;
            end else if (sw_write && !locked && paddr == 8'(i * 4)) begin
                wr_en[i]                     = 1'b1;
                wr_data[i*LIMIT_W +: LIMIT_W] = pwdata[LIMIT_W-1:0];
            end
        end
    end

    limit_word_bank #(
        .WORDS (4),
        .WIDTH (LIMIT_W)
    ) u_bank (
        .pclk    (pclk),
        .presetn (presetn),
        .ce      (ce),
        .wr_en   (wr_en),
        .wr_data (wr_data),
        .words   (words)
    );

    // ---------------------------------------------------------------
    // Control register and lock status
    // ---------------------------------------------------------------
    always_comb begin
        next_control = control;
        if (sw_write && paddr == `OFS_SEQ_CONTROL) begin
            next_control = pwdata[1:0];
        end
        next_locked = next_control[`BIT_SEQ_ENABLE] & next_control[`BIT_SEQ_START];
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            control          <= `RST_CONTROL;
            sequencer_locked <= 1'b0;
        end else if (ce) begin
            control          <= next_control;
            sequencer_locked <= next_locked;
        end
    end

    // ---------------------------------------------------------------
    // Limits applied on step commands, external copy loads
    // ---------------------------------------------------------------
    always_comb begin
        next_t0   = timer0_step_cmd ? timer0_limit : timer0_terminal;
        next_t1   = timer1_step_cmd ? timer1_limit : timer1_terminal;
        next_loop = counter1_jump_command ? counter1_limit : counter1_loop_count;
        next_gp   = counter1_gp_load ? counter1_limit : counter1_gp_limit;
        next_copy_load        = '0;
        next_copy_load.target = copy_hold_command.target;
        next_copy_load.data   = general_hold;
        next_copy_load.valid  = copy_hold_command.valid &&
                                (copy_hold_command.target == seq_limit_pkg::COPY_STEP_DELAY ||
                                 copy_hold_command.target == seq_limit_pkg::COPY_LITERAL0);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer0_terminal     <= `RST_LIMIT;
            timer1_terminal     <= `RST_LIMIT;
            counter1_loop_count <= `RST_LIMIT;
            counter1_gp_limit   <= `RST_LIMIT;
            copy_load           <= '0;
        end else if (ce) begin
            timer0_terminal     <= next_t0;
            timer1_terminal     <= next_t1;
            counter1_loop_count <= next_loop;
            counter1_gp_limit   <= next_gp;
            copy_load           <= next_copy_load;
        end
    end

    // ---------------------------------------------------------------
    // Assertions and covers
    // ---------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_T0_APPLY: assert property (ce && timer0_step_cmd |=> timer0_terminal == $past(timer0_limit))
        else $error("timer0 terminal not loaded");
    AST_T0_HOLD: assert property (!timer0_step_cmd |=> $stable(timer0_terminal))
        else $error("timer0 terminal moved without step");
    AST_T1_APPLY: assert property (ce && timer1_step_cmd |=> timer1_terminal == $past(timer1_limit))
        else $error("timer1 terminal not loaded");
    AST_LOCK_BLOCK: assert property (ce && sw_write && locked && !copy_hold_command.valid
                                     |=> $stable(timer0_limit) && $stable(general_hold))
        else $error("write altered locked register");
    AST_LOOP_COUNT: assert property (ce && counter1_jump_command |=> counter1_loop_count == $past(counter1_limit))
        else $error("loop count not loaded");
    AST_GP_LIMIT: assert property (ce && counter1_gp_load |=> counter1_gp_limit == $past(counter1_limit))
        else $error("counter1 limit not loaded");
    AST_COPY_T0: assert property (ce && copy_hold_command.valid && copy_hold_command.target == seq_limit_pkg::COPY_TIMER0
                                  |=> timer0_limit == $past(general_hold))
        else $error("copy to timer0 failed");
    AST_COPY_EXT: assert property (ce && copy_hold_command.valid && copy_hold_command.target == seq_limit_pkg::COPY_LITERAL0
                                   |=> copy_load.valid && copy_load.data == $past(general_hold))
        else $error("external copy failed");
    AST_WRITE_T0: assert property (ce && sw_write && !locked && !copy_hold_command.valid && paddr == `OFS_TIMER0_LIMIT
                                   |=> timer0_limit == $past(pwdata[15:0]))
        else $error("timer0 write lost");
    AST_READY_PULSE: assert property (ce && pready |=> !pready)
        else $error("ready held too long");
    AST_CE_FREEZE: assert property (!ce |=> $stable(timer0_terminal) && $stable(words))
        else $error("state moved while clock enable low");

    COV_WRITE: cover property (sw_write && !locked);
    COV_LOCKED_WRITE: cover property (sw_write && locked);
    COV_COPY: cover property (copy_hold_command.valid);
    COV_STEP: cover property (timer0_step_cmd ##1 timer1_step_cmd);

endmodule : seq_limit_regs

// [inc/seq_limit_cfg.svh]
// Purpose : Offsets, field positions, reset values for the limit/hold register bank
// Assumes : APB byte addresses, one aligned 32-bit word per register
// Notes   : Definitions only
`ifndef SEQ_LIMIT_CFG_SVH
`define SEQ_LIMIT_CFG_SVH

// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define OFS_TIMER0_LIMIT   8'h00
`define OFS_TIMER1_LIMIT   8'h04
`define OFS_COUNTER1_LIMIT 8'h08
`define OFS_GENERAL_HOLD   8'h0C
`define OFS_SEQ_CONTROL    8'h10
`define OFS_SEQ_STATUS     8'h14

// ---------------------------------------------------------------
// Fields and reset values
// ---------------------------------------------------------------
`define BIT_SEQ_ENABLE     0
`define BIT_SEQ_START      1
`define BIT_STAT_LOCKED    0
`define RST_LIMIT          16'h0000
`define RST_CONTROL        2'h0

`endif

// [inc/seq_limit_pkg.sv]
// Purpose : Types shared by the limit/hold register bank
// Assumes : Constants live in seq_limit_cfg.svh
// Notes   : Gray codes along idle, wait, done
package seq_limit_pkg;

    // ---------------------------------------------------------------
    // Bus handshake states
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {
        BUS_IDLE = 2'h0,
        BUS_WAIT = 2'h1,
        BUS_DONE = 2'h3
    } bus_state_t;

    // ---------------------------------------------------------------
    // Copy targets and carriers
    // ---------------------------------------------------------------
    typedef enum logic [2:0] {
        COPY_TIMER0     = 3'h0,
        COPY_TIMER1     = 3'h1,
        COPY_COUNTER1   = 3'h2,
        COPY_STEP_DELAY = 3'h3,
        COPY_LITERAL0   = 3'h4
    } copy_target_t;

    typedef struct packed {
        logic         valid;
        copy_target_t target;
    } copy_req_t;

    typedef struct packed {
        logic         valid;
        copy_target_t target;
        logic [15:0]  data;
    } ext_load_t;

endpackage : seq_limit_pkg

// [logic/limit_word_bank.sv]
// Purpose : Small bank of words, each with its own write enable
// Assumes : Single clock, clock enable freezes all words
// Notes   : Reset value of every word is zero
`timescale 1ns/10ps
module limit_word_bank #(
    parameter int WORDS = 4,
    parameter int WIDTH = 16
) (
    // Clock and reset
    input  wire logic                     pclk,
    input  wire logic                     presetn,
    input  wire logic                     ce,
    // Write side
    input  wire logic [WORDS-1:0]         wr_en,
    input  wire logic [WORDS*WIDTH-1:0]   wr_data,
    // Stored words
    output logic      [WORDS*WIDTH-1:0]   words
);

    // ---------------------------------------------------------------
    // Elaboration check
    // ---------------------------------------------------------------
    if (WORDS < 1 || WIDTH < 1 || WIDTH > 32) begin : g_bad
        $error("limit_word_bank: unsupported WORDS or WIDTH");
    end

    // ---------------------------------------------------------------
    // One register per entry
    // ---------------------------------------------------------------
    for (genvar i = 0; i < WORDS; i++) begin : g_word
        logic [WIDTH-1:0] next_word;

        // Load on write enable, else hold
        always_comb begin
            next_word = words[i*WIDTH +: WIDTH];
            if (wr_en[i]) begin
                next_word = wr_data[i*WIDTH +: WIDTH];
            end
        end

        // Register the entry
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                words[i*WIDTH +: WIDTH] <= '0;
            end else if (ce) begin
                words[i*WIDTH +: WIDTH] <= next_word;
            end
        end
    end

endmodule : limit_word_bank

// [dv/seq_limit_regs_bench.sv]
// Purpose : Self-checking bench for the limit/hold register bank over APB
// Assumes : One wait state per access, step and copy pulses answered next cycle
// Notes   : Random data from a fixed seed, corner cases for lock and unmapped places
`timescale 1ns/10ps
`include "seq_limit_cfg.svh"
module seq_limit_regs_bench;

    // ---------------------------------------------------------------
    // Signals
    // ---------------------------------------------------------------
    logic                      pclk, presetn, ce, psel, penable, pwrite, pready, pslverr;
    logic [7:0]                paddr;
    logic [31:0]               pwdata, prdata, rd_q, data;
    logic                      err_q;
    logic [3:0]                cmd;
    seq_limit_pkg::copy_req_t  copy_req;
    seq_limit_pkg::ext_load_t  copy_load;
    logic                      sequencer_locked;
    logic [15:0]               outs [4];
    logic [15:0]               exp_out [4];
    logic [15:0]               model [4];
    logic [1:0]                ctrl;
    integer                    seed, error_cnt, checked, k;

    seq_limit_regs seq_limit_regs_inst (
        .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .timer0_step_cmd(cmd[0]), .timer1_step_cmd(cmd[1]), .counter1_jump_command(cmd[2]),
        .counter1_gp_load(cmd[3]), .copy_hold_command(copy_req),
        .timer0_terminal(outs[0]), .timer1_terminal(outs[1]), .counter1_loop_count(outs[2]),
        .counter1_gp_limit(outs[3]), .copy_load(copy_load), .sequencer_locked(sequencer_locked)
    );

    // Free-running 10 MHz clock
    always #50 pclk = ~pclk;

    // ---------------------------------------------------------------
    // Expectations and checks
    // ---------------------------------------------------------------
    // Read value of an aligned address from the bench's register image
    function automatic logic [31:0] exp_read(input logic [7:0] a);
        if (a < `OFS_SEQ_CONTROL) return {16'h0000, model[a[3:2]]};
        if (a == `OFS_SEQ_CONTROL) return {30'h0, ctrl};
        if (a == `OFS_SEQ_STATUS) return {31'h0, ctrl == 2'h3};
        return 32'h0;
    endfunction : exp_read

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            $display("ERROR %s expected %h seen %h", name, exp, got);
            error_cnt++;
        end
    endtask : chk

    task automatic give_verdict();
        $display("Checks made %0d, mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : give_verdict

    // One APB transfer; holds the request until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) begin
            chk("pready", 32'h1, {31'h0, pready});
            give_verdict();
        end
        rd_q = prdata;
        err_q = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd_chk(input logic [7:0] a, input logic exp_err);
        apb(1'b0, a, 32'h0);
        chk("prdata", exp_read(a), rd_q);
        chk("pslverr", {31'h0, exp_err}, {31'h0, err_q});
    endtask : rd_chk

    // Writes a random word to all four limit/hold places
    task automatic wr_all();
        data = $random(seed);
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, 8'(i * 4), data);
            if (ctrl != 2'h3) model[i] = data[15:0];
        end
    endtask : wr_all

    // ---------------------------------------------------------------
    // Main sequence
    // ---------------------------------------------------------------
    initial begin
        pclk = 1'b0; presetn = 1'b0; ce = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 8'h00; pwdata = 32'h0; cmd = 4'h0; copy_req = '0;
        seed = 32'h850C; error_cnt = 0; checked = 0; ctrl = 2'h0;
        for (int i = 0; i < 4; i++) begin
            model[i] = 16'h0000;
            exp_out[i] = 16'h0000;
        end
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        // Reset values of every register
        for (int a = 0; a < 24; a += 4) rd_chk(8'(a), 1'b0);
        // Random writes and full-width read-back
        repeat (4) begin
            wr_all();
            for (int a = 0; a < 16; a += 4) rd_chk(8'(a), 1'b0);
        end
        // Step commands pick up only their own limit
        repeat (12) begin
            k = $random(seed) & 3;
            @(posedge pclk);
            cmd[k] <= 1'b1;
            @(posedge pclk);
            cmd <= 4'h0;
            @(posedge pclk);
            exp_out[k] = model[k == 3 ? 2 : k];
            for (int i = 0; i < 4; i++) chk("step output", {16'h0, exp_out[i]}, {16'h0, outs[i]});
            if (($random(seed) & 1) != 0) wr_all();
        end
        // Clock enable low freezes the step outputs, even with every command raised
        @(posedge pclk);
        ce  <= 1'b0;
        cmd <= 4'hF;
        repeat (2) @(posedge pclk);
        ce  <= 1'b1;
        cmd <= 4'h0;
        @(posedge pclk);
        for (int i = 0; i < 4; i++) chk("frozen output", {16'h0, exp_out[i]}, {16'h0, outs[i]});
        // Unmapped place and read-only status
        rd_chk(8'h18, 1'b1);
        apb(1'b1, 8'h20, 32'hFFFF_FFFF);
        chk("pslverr", 32'h1, {31'h0, err_q});
        apb(1'b1, `OFS_SEQ_STATUS, 32'hFFFF_FFFF);
        rd_chk(`OFS_SEQ_STATUS, 1'b0);
        // Lock only with both control bits set
        for (int v = 0; v < 4; v++) begin
            apb(1'b1, `OFS_SEQ_CONTROL, 32'(v));
            ctrl = 2'(v);
            wr_all();
            for (int a = 0; a < 24; a += 4) rd_chk(8'(a), 1'b0);
            chk("locked", {31'h0, ctrl == 2'h3}, {31'h0, sequencer_locked});
        end
        // Copy of the hold word to every target while locked
        for (int t = 0; t < 8; t++) begin
            @(posedge pclk);
            copy_req <= '{valid: 1'b1, target: seq_limit_pkg::copy_target_t'(t)};
            @(posedge pclk);
            copy_req <= '0;
            @(posedge pclk);
            if (t < 3) model[t] = model[3];
            if (t == 3 || t == 4) begin
                chk("copy_load", {12'h0, 1'b1, 3'(t), model[3]}, {12'h0, copy_load});
            end else begin
                chk("copy_load valid", 32'h0, {31'h0, copy_load.valid});
            end
        end
        for (int a = 0; a < 16; a += 4) rd_chk(8'(a), 1'b0);
        // Unlock and prove writes land again
        apb(1'b1, `OFS_SEQ_CONTROL, 32'h0);
        ctrl = 2'h0;
        wr_all();
        for (int a = 0; a < 24; a += 4) rd_chk(8'(a), 1'b0);
        // Mid-run reset clears every register and every output
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        ctrl = 2'h0;
        for (int i = 0; i < 4; i++) begin
            model[i] = 16'h0000;
            chk("reset output", 32'h0, {16'h0, outs[i]});
        end
        for (int a = 0; a < 24; a += 4) rd_chk(8'(a), 1'b0);
        give_verdict();
    end

endmodule : seq_limit_regs_bench
